// ### shared/modbus_port_pkg.sv
// Constants and helpers shared by the serial slave port
package modbus_port_pkg;

  // ----
  // Timing
  // ----
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RATE0_BPS = 4800;
  localparam int unsigned RATE1_BPS = 9600;
  localparam int unsigned RATE2_BPS = 19200;
  localparam int unsigned RATE3_BPS = 38400;
  localparam int unsigned TENTH_S_MS = 100;
  localparam int unsigned TENTH_CYC = CLK_HZ / 1000 * TENTH_S_MS;
  localparam int unsigned RTU_GAP_MS = 10;
  // Silence must be longer than the gap, so one cycle more
  localparam int unsigned RTU_GAP_CYC = CLK_HZ / 1000 * RTU_GAP_MS + 1;

  // ----
  // Register offsets and fields
  // ----
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMEOUT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_RXDATA = 8'h10;
  localparam int CTRL_STATION_LSB = 0;
  localparam int CTRL_RATE_LSB = 8;
  localparam int CTRL_FAULT_LSB = 10;
  localparam int CTRL_PROTO_LSB = 12;
  localparam int ST_RX_ERR = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_FRAME = 2;
  localparam int ST_W = 3;

  // ----
  // Reset values and limits
  // ----
  localparam logic [7:0] STATION_RST = 8'h01;
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hFE;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [1:0] RATE_RST = 2'h1;
  localparam logic [1:0] FAULT_RST = 2'h3;
  localparam logic [3:0] PROTO_RST = 4'h0;
  localparam logic [3:0] PROTO_MAX = 4'hB;
  localparam logic [10:0] TIMEOUT_RST = 11'h000;
  localparam logic [10:0] TIMEOUT_MAX = 11'h4B0;
  localparam logic [1:0] FLT_WARN_RUN = 2'h0;
  localparam logic [1:0] FLT_RAMP = 2'h1;
  localparam logic [1:0] FLT_COAST = 2'h2;
  localparam logic [1:0] FLT_SILENT = 2'h3;

  // ----
  // Characters
  // ----
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;

  typedef struct packed {
    logic rtu;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
  } frame_fmt_t;

  function automatic frame_fmt_t proto_fmt(input logic [3:0] code);
    case (code)
      4'h0: proto_fmt = 4'b0001;
      4'h1: proto_fmt = 4'b0100;
      4'h2: proto_fmt = 4'b0110;
      4'h3: proto_fmt = 4'b1001;
      4'h4: proto_fmt = 4'b1100;
      4'h5: proto_fmt = 4'b1110;
      4'h6: proto_fmt = 4'b1000;
      4'h7: proto_fmt = 4'b1101;
      4'h8: proto_fmt = 4'b1111;
      4'h9: proto_fmt = 4'b0000;
      4'hA: proto_fmt = 4'b0101;
      4'hB: proto_fmt = 4'b0111;
      default: proto_fmt = 4'b0001;
    endcase
  endfunction : proto_fmt

  function automatic logic [15:0] bit_cycles(input logic [1:0] rate);
    case (rate)
      2'h0: bit_cycles = 16'(CLK_HZ / RATE0_BPS);
      2'h1: bit_cycles = 16'(CLK_HZ / RATE1_BPS);
      2'h2: bit_cycles = 16'(CLK_HZ / RATE2_BPS);
      default: bit_cycles = 16'(CLK_HZ / RATE3_BPS);
    endcase
  endfunction : bit_cycles

endpackage : modbus_port_pkg

// ### shared/serial_frame_if.sv
// Character link between the frame logic and the bit engines
`timescale 1ns/100ps
`default_nettype none
interface serial_frame_if;
  logic [15:0] bit_cycles;
  logic seven_bits;
  logic parity_en;
  logic parity_odd;
  logic two_stop;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_err;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  modport rx (input bit_cycles, seven_bits, parity_en, parity_odd,
    two_stop, output rx_data, rx_valid, rx_err);
  modport tx (input bit_cycles, seven_bits, parity_en, parity_odd,
    two_stop, tx_data, tx_valid, output tx_ready);
endinterface : serial_frame_if
`default_nettype wire

// ### hdl/serial_char_rx.sv
// Character receiver with parity and stop checks
`timescale 1ns/100ps
`default_nettype none
module serial_char_rx
  import modbus_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic rx_line,
  serial_frame_if.rx sf
);
  typedef enum logic [2:0] {
    R_IDLE = 3'b001,
    R_START = 3'b010,
    R_BITS = 3'b100
  } rx_st_t;
  typedef struct packed {
    rx_st_t st;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [10:0] sh;
    logic [7:0] data;
    logic valid;
    logic err;
  } rx_t;
  rx_t r;
  rx_t next_r;

  always_comb begin
    logic [3:0] nd;
    logic [3:0] nbits;
    logic [3:0] ps;
    logic bad;
    nd = sf.seven_bits ? 4'h7 : 4'h8;
    ps = nd + {3'h0, sf.parity_en};
    nbits = ps + 4'h1 + {3'h0, sf.two_stop};
    bad = 1'b0;
    next_r = r;
    next_r.valid = 1'b0;
    next_r.err = 1'b0;
    case (r.st)
      R_IDLE: begin
        if (!rx_line) begin
          next_r.st = R_START;
          next_r.cnt = sf.bit_cycles >> 1;
        end
      end
      R_START: begin
        if (r.cnt == 16'h0000) begin
          // A short low glitch is not a start bit
          next_r.st = rx_line ? R_IDLE : R_BITS;
          next_r.cnt = sf.bit_cycles - 16'h0001;
          next_r.idx = 4'h0;
        end else begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      R_BITS: begin
        if (r.cnt == 16'h0000) begin
          next_r.sh[r.idx] = rx_line;
          next_r.cnt = sf.bit_cycles - 16'h0001;
          next_r.idx = r.idx + 4'h1;
          if (r.idx == nbits - 4'h1) begin
            next_r.st = R_IDLE;
            next_r.data = sf.seven_bits ? {1'b0, next_r.sh[6:0]}
                                        : next_r.sh[7:0];
            if (sf.parity_en &&
                ((^next_r.data ^ next_r.sh[nd]) != sf.parity_odd))
              bad = 1'b1;
            if (!next_r.sh[ps] || (sf.two_stop && !next_r.sh[ps + 4'h1]))
              bad = 1'b1;
            next_r.valid = !bad;
            next_r.err = bad;
          end
        end else begin
          next_r.cnt = r.cnt - 16'h0001;
        end
      end
      default: next_r.st = R_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: R_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign sf.rx_data = r.data;
  assign sf.rx_valid = r.valid;
  assign sf.rx_err = r.err;
endmodule : serial_char_rx
`default_nettype wire

// ### hdl/serial_char_tx.sv
// Character transmitter for the selected frame format
`timescale 1ns/100ps
`default_nettype none
module serial_char_tx
  import modbus_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  serial_frame_if.tx sf,
  output logic tx_line,
  output logic tx_line_en
);
  typedef struct packed {
    logic busy;
    logic ready;
    logic line;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [3:0] len;
    logic [11:0] sh;
  } tx_t;
  tx_t r;
  tx_t next_r;

  always_comb begin
    logic [3:0] nd;
    logic [7:0] d;
    nd = sf.seven_bits ? 4'h7 : 4'h8;
    d = sf.seven_bits ? {1'b0, sf.tx_data[6:0]} : sf.tx_data;
    next_r = r;
    if (!r.busy) begin
      if (sf.tx_valid && r.ready) begin
        next_r.sh = '1;
        next_r.sh[0] = 1'b0;
        next_r.sh[8:1] = d;
        if (sf.seven_bits)
          next_r.sh[8] = 1'b1;
        if (sf.parity_en)
          next_r.sh[4'h1 + nd] = ^d ^ sf.parity_odd;
        next_r.len = nd + 4'h2 + {3'h0, sf.parity_en}
                     + {3'h0, sf.two_stop};
        next_r.busy = 1'b1;
        next_r.ready = 1'b0;
        next_r.idx = 4'h0;
        next_r.cnt = sf.bit_cycles - 16'h0001;
        next_r.line = 1'b0;
      end
    end else if (r.cnt == 16'h0000) begin
      next_r.idx = r.idx + 4'h1;
      next_r.cnt = sf.bit_cycles - 16'h0001;
      if (r.idx + 4'h1 == r.len) begin
        next_r.busy = 1'b0;
        next_r.ready = 1'b1;
        next_r.line = 1'b1;
      end else begin
        next_r.line = r.sh[r.idx + 4'h1];
      end
    end else begin
      next_r.cnt = r.cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{ready: 1'b1, line: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign sf.tx_ready = r.ready;
  assign tx_line = r.line;
  assign tx_line_en = r.busy;
endmodule : serial_char_tx
`default_nettype wire

// ### hdl/modbus_serial_slave_port.sv
// Serial slave port: setup registers, framing, addressing, faults
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Station address held, only 1 to 254
// - Act only on frames carrying own or broadcast address
// - Rate code selects 4800 to 38400 bps
// - Fault code selects warn, ramp, coast, silent
// - Bus silence reaching a nonzero timeout raises warning unless fault code is silent
// - Protocol code selects mode, parity, stops
// - ASCII character: start, 7 data, optional parity, 1 or 2 stops
// - ASCII sends byte as two hex characters
// - Hex digits map to 30H-39H, 41H-46H
// - RTU sends byte as one raw character
// - RTU frames bounded by silence over 10 ms
// - ASCII frame starts with colon character
// - Address zero is broadcast, no reply
module modbus_serial_slave_port
  import modbus_port_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = TENTH_CYC,
  parameter int unsigned GAP_CYCLES = RTU_GAP_CYC
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_line_en,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic frame_done,
  output logic frame_bcast,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  output logic comm_warn,
  output logic ramp_stop_req,
  output logic coast_stop_req,
  output logic bus_idle_timeout_warning
);
  // ----
  // Elaboration checks
  // ----
  if (TENTH_CYCLES < 1 || TENTH_CYCLES >= (1 << 24)) begin : g_bad_tenth
    $error("TENTH_CYCLES out of range");
  end
  if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << 24)) begin : g_bad_gap
    $error("GAP_CYCLES out of range");
  end

  localparam logic [23:0] TENTH_LAST = 24'(TENTH_CYCLES - 1);
  localparam logic [23:0] GAP_LAST = 24'(GAP_CYCLES - 1);

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_HI = 3'b010,
    RX_LO = 3'b100
  } rx_st_t;
  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_COLON = 6'b000010,
    TX_HI = 6'b000100,
    TX_LO = 6'b001000,
    TX_CR = 6'b010000,
    TX_LF = 6'b100000
  } tx_st_t;
  typedef struct packed {
    logic [7:0] station;
    logic [1:0] rate;
    logic [1:0] fault;
    logic [3:0] proto;
    logic [10:0] timeout;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [31:0] rdata;
    logic irq;
    rx_st_t rxs;
    logic [3:0] nib;
    logic first;
    logic accept;
    logic bcast;
    logic [23:0] gap_cnt;
    logic gap_armed;
    logic [23:0] tenth_cnt;
    logic [10:0] idle_tenths;
    logic [7:0] last_rx;
    logic [7:0] out_data;
    logic out_valid;
    logic done;
    logic idle_warn;
    logic warn;
    logic ramp;
    logic coast;
    tx_st_t txs;
    logic [7:0] hold;
    logic last;
    logic open;
    logic ready;
    logic [7:0] ch;
    logic ch_valid;
  } port_t;
  port_t r;
  port_t next_r;
  frame_fmt_t fmt;

  serial_frame_if sf ();

  // ----
  // Bit engines
  // ----
  assign fmt = proto_fmt(r.proto);
  assign sf.bit_cycles = bit_cycles(r.rate);
  assign sf.seven_bits = !fmt.rtu;
  assign sf.parity_en = fmt.parity_en;
  assign sf.parity_odd = fmt.parity_odd;
  assign sf.two_stop = fmt.two_stop;
  assign sf.tx_data = r.ch;
  assign sf.tx_valid = r.ch_valid;

  serial_char_rx u_rx (
    .core_clk(core_clk),
    .resetn(resetn),
    .rx_line(rx_line),
    .sf(sf)
  );

  serial_char_tx u_tx (
    .core_clk(core_clk),
    .resetn(resetn),
    .sf(sf),
    .tx_line(tx_line),
    .tx_line_en(tx_line_en)
  );

  // ----
  // Hex coding
  // ----
  function automatic logic [7:0] to_hex(input logic [3:0] n);
    to_hex = (n < 4'hA) ? CH_ZERO + {4'h0, n}
                        : CH_A + {4'h0, n - 4'hA};
  endfunction : to_hex

  function automatic logic [4:0] from_hex(input logic [7:0] c);
    // Upper case only; bit 4 flags a valid digit
    if (c >= CH_ZERO && c <= CH_NINE)
      from_hex = {1'b1, 4'(c - CH_ZERO)};
    else if (c >= CH_A && c <= CH_F)
      from_hex = {1'b1, 4'(c - CH_A + 8'h0A)};
    else
      from_hex = 5'h00;
  endfunction : from_hex

  // ----
  // Next state
  // ----
  always_comb begin
    logic [ST_W-1:0] set;
    logic [ST_W-1:0] clr;
    logic [4:0] hx;
    logic [7:0] b;
    logic got;
    logic ends;
    logic idle_hit;
    logic tx_take;
    set = '0;
    clr = '0;
    hx = from_hex(sf.rx_data);
    b = 8'h00;
    got = 1'b0;
    ends = 1'b0;
    next_r = r;
    next_r.rdata = 32'h0000_0000;
    next_r.out_valid = 1'b0;
    next_r.done = 1'b0;
    next_r.ch_valid = 1'b0;

    // Register writes
    if (wr) begin
      case (addr)
        REG_CTRL: begin
          if (wdata[CTRL_STATION_LSB +: 8] >= STATION_MIN &&
              wdata[CTRL_STATION_LSB +: 8] <= STATION_MAX)
            next_r.station = wdata[CTRL_STATION_LSB +: 8];
          next_r.rate = wdata[CTRL_RATE_LSB +: 2];
          next_r.fault = wdata[CTRL_FAULT_LSB +: 2];
          if (wdata[CTRL_PROTO_LSB +: 4] <= PROTO_MAX)
            next_r.proto = wdata[CTRL_PROTO_LSB +: 4];
        end
        REG_TIMEOUT: begin
          if (wdata[10:0] <= TIMEOUT_MAX && wdata[31:11] == '0)
            next_r.timeout = wdata[10:0];
        end
        REG_STATUS: clr = wdata[ST_W-1:0];
        REG_MASK: next_r.mask = wdata[ST_W-1:0];
        default: ;
      endcase
    end

    // Register reads; unmapped reads return zero
    if (rd) begin
      case (addr)
        REG_CTRL: next_r.rdata = {16'h0000, r.proto, r.fault,
                                  r.rate, r.station};
        REG_TIMEOUT: next_r.rdata = {21'h000000, r.timeout};
        REG_STATUS: next_r.rdata = {29'h0, r.status};
        REG_MASK: next_r.rdata = {29'h0, r.mask};
        REG_RXDATA: next_r.rdata = {24'h000000, r.last_rx};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    // RTU silence tracking
    if (sf.rx_valid || sf.rx_err) begin
      next_r.gap_cnt = 24'h000000;
      next_r.gap_armed = 1'b1;
    end else if (r.gap_armed) begin
      if (r.gap_cnt == GAP_LAST) begin
        next_r.gap_armed = 1'b0;
        if (fmt.rtu) begin
          ends = !r.first;
          next_r.first = 1'b1;
        end
      end else begin
        next_r.gap_cnt = r.gap_cnt + 24'h000001;
      end
    end

    // Character decode
    if (sf.rx_err) begin
      set[ST_RX_ERR] = 1'b1;
      next_r.accept = 1'b0;
      next_r.rxs = RX_HUNT;
    end else if (sf.rx_valid) begin
      next_r.last_rx = sf.rx_data;
      if (fmt.rtu) begin
        got = 1'b1;
        b = sf.rx_data;
      end else if (sf.rx_data == CH_COLON) begin
        next_r.rxs = RX_HI;
        next_r.first = 1'b1;
      end else begin
        case (r.rxs)
          RX_HI: begin
            if (sf.rx_data == CH_CR) begin
              ends = !r.first;
              next_r.rxs = RX_HUNT;
            end else if (hx[4]) begin
              next_r.nib = hx[3:0];
              next_r.rxs = RX_LO;
            end else begin
              set[ST_RX_ERR] = 1'b1;
              next_r.rxs = RX_HUNT;
            end
          end
          RX_LO: begin
            next_r.rxs = RX_HI;
            if (hx[4]) begin
              got = 1'b1;
              b = {r.nib, hx[3:0]};
            end else begin
              set[ST_RX_ERR] = 1'b1;
              next_r.rxs = RX_HUNT;
            end
          end
          default: next_r.rxs = RX_HUNT;
        endcase
      end
    end

    if (got) begin
      if (r.first) begin
        next_r.first = 1'b0;
        next_r.accept = (b == r.station) || (b == BCAST_ADDR);
        next_r.bcast = (b == BCAST_ADDR);
      end else if (r.accept) begin
        next_r.out_data = b;
        next_r.out_valid = 1'b1;
      end
    end
    if (ends && r.accept) begin
      next_r.done = 1'b1;
      set[ST_FRAME] = 1'b1;
      next_r.accept = 1'b0;
    end

    // Idle timeout in tenths of a second
    if (sf.rx_valid || sf.rx_err) begin
      next_r.tenth_cnt = 24'h000000;
      next_r.idle_tenths = 11'h000;
    end else if (r.tenth_cnt == TENTH_LAST) begin
      next_r.tenth_cnt = 24'h000000;
      if (r.idle_tenths != TIMEOUT_MAX)
        next_r.idle_tenths = r.idle_tenths + 11'h001;
    end else begin
      next_r.tenth_cnt = r.tenth_cnt + 24'h000001;
    end
    idle_hit = (r.timeout != 11'h000) && (r.fault != FLT_SILENT)
               && (r.idle_tenths >= r.timeout);
    next_r.idle_warn = idle_hit && !(sf.rx_valid || sf.rx_err);
    if (idle_hit && !r.idle_warn)
      set[ST_TIMEOUT] = 1'b1;

    // Set wins over a same-cycle clear
    next_r.status = (r.status & ~clr) | set;
    next_r.irq = |(next_r.status & r.mask);

    // Fault reaction latched until the error bit is cleared
    next_r.warn = next_r.status[ST_RX_ERR]
                  && (r.fault != FLT_SILENT);
    next_r.ramp = next_r.status[ST_RX_ERR] && (r.fault == FLT_RAMP);
    next_r.coast = next_r.status[ST_RX_ERR]
                   && (r.fault == FLT_COAST);

    // Reply encoder
    tx_take = tx_valid && r.ready;
    if (tx_take) begin
      next_r.hold = tx_data;
      next_r.last = tx_last;
      if (r.bcast) begin
        next_r.txs = TX_IDLE;
      end else if (fmt.rtu) begin
        next_r.txs = TX_LO;
      end else begin
        next_r.txs = r.open ? TX_HI : TX_COLON;
      end
    end
    if (sf.tx_ready && !r.ch_valid) begin
      case (r.txs)
        TX_COLON: begin
          next_r.ch = CH_COLON;
          next_r.open = 1'b1;
          next_r.txs = TX_HI;
        end
        TX_HI: begin
          next_r.ch = to_hex(r.hold[7:4]);
          next_r.txs = TX_LO;
        end
        TX_LO: begin
          next_r.ch = fmt.rtu ? r.hold : to_hex(r.hold[3:0]);
          next_r.txs = (!fmt.rtu && r.last) ? TX_CR : TX_IDLE;
        end
        TX_CR: begin
          next_r.ch = CH_CR;
          next_r.txs = TX_LF;
        end
        TX_LF: begin
          next_r.ch = CH_LF;
          next_r.open = 1'b0;
          next_r.txs = TX_IDLE;
        end
        default: ;
      endcase
      next_r.ch_valid = (r.txs != TX_IDLE);
    end
    next_r.ready = (next_r.txs == TX_IDLE) && !tx_take;
  end

  // ----
  // State register
  // ----
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '{station: STATION_RST, rate: RATE_RST, fault: FAULT_RST,
             proto: PROTO_RST, timeout: TIMEOUT_RST, rxs: RX_HUNT,
             first: 1'b1, txs: TX_IDLE, ready: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign irq = r.irq;
  assign rx_data = r.out_data;
  assign rx_valid = r.out_valid;
  assign frame_done = r.done;
  assign frame_bcast = r.bcast;
  assign tx_ready = r.ready;
  assign comm_warn = r.warn;
  assign ramp_stop_req = r.ramp;
  assign coast_stop_req = r.coast;
  assign bus_idle_timeout_warning = r.idle_warn;
endmodule : modbus_serial_slave_port
`default_nettype wire

// ### verif/modbus_serial_slave_port_assertions.sv
// Port-level checks for the serial slave port
`timescale 1ns/100ps
`default_nettype none
module modbus_serial_slave_port_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire logic tx_line,
  input wire logic tx_line_en,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic frame_bcast,
  input wire logic comm_warn,
  input wire logic ramp_stop_req,
  input wire logic coast_stop_req
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ----
  // Sequences and properties
  // ----
  // Shortest bit at any rate is far above eight cycles
  sequence s_line_low8;
    !tx_line [*8];
  endsequence
  sequence s_busy8;
    !tx_ready [*8];
  endsequence
  property p_rdata_slot;
    rdata != 32'h0 |-> $past(rd);
  endproperty
  property p_rd_quiet;
    rd ##1 !rd |=> rdata == 32'h0;
  endproperty
  // Status only falls through a register write
  property p_irq_hold;
    irq && !wr && !$past(wr) |=> irq;
  endproperty
  property p_idle_high;
    !tx_line_en |-> tx_line;
  endproperty
  property p_low_driven;
    !tx_line |-> tx_line_en;
  endproperty
  property p_start_len;
    $fell(tx_line) |-> s_line_low8;
  endproperty
  property p_take;
    tx_valid && tx_ready && !frame_bcast |=> s_busy8;
  endproperty
  property p_ramp_pair;
    ramp_stop_req |-> comm_warn && !coast_stop_req;
  endproperty
  a_rdata_slot: assert property (p_rdata_slot)
    else $error("rdata off slot");
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("rdata held");
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped");
  a_idle_high: assert property (p_idle_high)
    else $error("idle not high");
  a_low_driven: assert property (p_low_driven)
    else $error("low undriven");
  a_start_len: assert property (p_start_len)
    else $error("start short");
  a_take: assert property (p_take)
    else $error("ready early");
  a_ramp_pair: assert property (p_ramp_pair)
    else $error("ramp pairing");
endmodule : modbus_serial_slave_port_checker
`default_nettype wire

// ### verif/rs485_master_model.sv
// Behavioural bus master on the far side of the serial port
`timescale 1ns/100ps
`default_nettype none
module rs485_master_model #(
  parameter int BIT = 2604
)(
  input wire logic core_clk,
  output logic rx_line,
  input wire logic tx_line,
  input wire logic tx_line_en
);
  // Released driver reads as idle through the line bias
  wire logic bus = tx_line_en ? tx_line : 1'b1;
  // Long idle before any frame; no communication reset is ever sent
  initial rx_line = 1'b1;
  task automatic send_bit(input logic b);
    rx_line <= b;
    repeat (BIT) @(posedge core_clk);
  endtask : send_bit
  // Seven data bits, even parity; bad flips the parity bit
  task automatic send_char(input logic [7:0] d, input logic bad);
    @(posedge core_clk);
    send_bit(1'b0);
    for (int i = 0; i < 7; i++) begin
      send_bit(d[i]);
    end
    send_bit(^d[6:0] ^ bad);
    send_bit(1'b1);
  endtask : send_char
  // Seven-bit character; first stop sample lands in bit 7
  task automatic get_char(output logic [7:0] c);
    c = 8'h00;
    while (bus !== 1'b0) @(posedge core_clk);
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge core_clk);
      c[i] = bus;
    end
  endtask : get_char
endmodule : rs485_master_model
`default_nettype wire

// ### verif/modbus_serial_slave_port_tb.sv
// Self-checking testbench for the serial slave port
`timescale 1ns/100ps
`default_nettype none
module modbus_serial_slave_port_tb
  import modbus_port_pkg::*;
;
  localparam int BIT = CLK_HZ / RATE3_BPS;
  localparam int LIMIT = 130000;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic [31:0] rdata;
  logic [7:0] rx_data;
  logic irq, rx_line, tx_line, tx_line_en, rx_valid, frame_done;
  logic frame_bcast, tx_ready, comm_warn, ramp_stop_req, coast_stop_req;
  logic bus_idle_timeout_warning;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  wire logic [31:0] flags = {rx_data, 16'h0, frame_bcast, frame_done,
    rx_valid, bus_idle_timeout_warning, comm_warn, ramp_stop_req,
    coast_stop_req, irq};
  always #5 core_clk = ~core_clk;
  modbus_serial_slave_port #(.TENTH_CYCLES(100), .GAP_CYCLES(50)) DUT (
    .core_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .irq, .rx_line,
    .tx_line, .tx_line_en, .rx_data, .rx_valid, .frame_done, .frame_bcast,
    .tx_data, .tx_valid, .tx_last, .tx_ready, .comm_warn, .ramp_stop_req,
    .coast_stop_req, .bus_idle_timeout_warning);
  rs485_master_model #(.BIT(BIT)) master (.core_clk, .rx_line, .tx_line,
    .tx_line_en);
  // ----
  // Bus and compare tasks
  // ----
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input string name, input logic [7:0] a,
      input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 check(name, rdata, exp);
  endtask : rd_chk
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rd_chk("ctrl", REG_CTRL, 32'h0000_0D01);
    rd_chk("timeout", REG_TIMEOUT, 32'h0);
    wr_reg(REG_CTRL, 32'h0000_0900);
    rd_chk("station0", REG_CTRL, 32'h0000_0901);
    wr_reg(REG_CTRL, 32'h0000_05FF);
    rd_chk("station255", REG_CTRL, 32'h0000_0501);
    wr_reg(REG_CTRL, 32'h0000_C5FE);
    rd_chk("station254", REG_CTRL, 32'h0000_05FE);
    wr_reg(REG_TIMEOUT, 32'h0000_04B1);
    rd_chk("tmo_over", REG_TIMEOUT, 32'h0);
    wr_reg(REG_TIMEOUT, 32'h0000_04B0);
    rd_chk("tmo_max", REG_TIMEOUT, 32'h0000_04B0);
    wr_reg(8'h20, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h20, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic t_timeout;
    wr_reg(REG_CTRL, 32'h0000_0F01);
    wr_reg(REG_MASK, 32'h2);
    wr_reg(REG_TIMEOUT, 32'h1);
    repeat (250) @(posedge core_clk);
    check("silent_flags", flags, 32'h0);
    wr_reg(REG_CTRL, 32'h0000_0301);
    repeat (250) @(posedge core_clk);
    check("warn_flags", flags, 32'h11);
    wr_reg(REG_MASK, 32'h0);
    repeat (3) @(posedge core_clk);
    check("masked", flags, 32'h10);
    wr_reg(REG_TIMEOUT, 32'h0);
    wr_reg(REG_STATUS, 32'h2);
    wr_reg(REG_MASK, 32'h2);
    repeat (3) @(posedge core_clk);
    check("irq_clear", flags & 32'h1, 32'h0);
    $display("timeout test done");
  endtask : t_timeout
  task automatic t_rx_error;
    wr_reg(REG_CTRL, 32'h0000_1701);
    wr_reg(REG_MASK, 32'h1);
    master.send_char(CH_COLON, 1'b1);
    repeat (20) @(posedge core_clk);
    rd_chk("status", REG_STATUS, 32'h1);
    check("ramp_flags", flags & 32'hF, 32'hD);
    wr_reg(REG_STATUS, 32'h1);
    repeat (3) @(posedge core_clk);
    check("cleared", flags & 32'hF, 32'h0);
    $display("receive error test done");
  endtask : t_rx_error
  // Stop bit reads back in bit 7 of each character
  task automatic t_tx_ascii;
    logic [7:0] c;
    wr_reg(REG_CTRL, 32'h0000_0F01);
    @(posedge core_clk);
    tx_data <= 8'h64;
    tx_valid <= 1'b1;
    @(posedge core_clk);
    while (tx_ready !== 1'b1) @(posedge core_clk);
    tx_valid <= 1'b0;
    master.get_char(c);
    check("colon", {24'h0, c}, 32'h0000_00BA);
    master.get_char(c);
    check("high", {24'h0, c}, 32'h0000_00B6);
    master.get_char(c);
    check("low", {24'h0, c}, 32'h0000_00B4);
    for (int i = 0; i < 3 * BIT && tx_ready !== 1'b1; i++)
      @(posedge core_clk);
    check("ready", {31'h0, tx_ready}, 32'h1);
    $display("transmit test done");
  endtask : t_tx_ascii
  // ----
  // Sequence and watchdog
  // ----
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_timeout;
    t_rx_error;
    t_tx_ascii;
    tally_and_finish;
  end
endmodule : modbus_serial_slave_port_tb
bind modbus_serial_slave_port modbus_serial_slave_port_checker chk (
  .core_clk, .resetn, .wr, .rd, .rdata, .irq, .tx_line, .tx_line_en,
  .tx_valid, .tx_ready, .frame_bcast, .comm_warn, .ramp_stop_req,
  .coast_stop_req);
`default_nettype wire
